/* File: wake_map.vh */
// register offsets, field positions and reset values of the wake-up unit
`ifndef WAKE_MAP_VH
`define WAKE_MAP_VH
`define WAKE_CONTROL_IDX 8'hf9
`define WAKE_MASK_HIGH_IDX 8'hfa
`define WAKE_MASK_LOW_IDX 8'hfb
`define WAKE_POLARITY_HIGH_IDX 8'hfc
`define WAKE_POLARITY_LOW_IDX 8'hfd
`define WAKE_PENDING_HIGH_IDX 8'hfe
`define WAKE_PENDING_LOW_IDX 8'hff
`define WAKE_STATUS_IDX 8'hf8
`define CTRL_WAKE_MODE_BIT 0
`define CTRL_SOURCE_SEL_BIT 1
`define CTRL_STOP_BIT 2
`define REG_RESET 8'h00
`define PULSE_GAP_CYCLES 1
`endif

/* File: line_sync.v */
// two-flop synchroniser for a group of asynchronous input lines
`timescale 1ns/1ps
module line_sync #(
    parameter WIDTH = 17
)
(
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule

/* File: wakeup_line_interrupt_unit.v */
// wake-up line interrupt unit with guarded stop request, AHB-Lite slave
`timescale 1ns/1ps
`include "wake_map.vh"

// Functional notes
// - stop needs writes of 1, 0, 1 to the stop bit, three in a row.
// - accept stop only with NMI low, wake mode, no unmasked pending, a mask.
// - valid sequence sets stop bit and raises stop request to clock unit.
// - any other register write during the sequence cancels it.
// - wake-up from an unmasked line in stop mode clears stop bit.
// - NMI rising edge ending stop leaves the stop bit set.
// - stop bit reads 1 after first write and after a successful third.
// - correct sequence with NMI high: bit reads 1, no stop request.
// - stop request is ORed with the active-low external stop pin.
// - source select must be 1 for lines to drive the shared channel.
// - wake mode select: 0 interrupt sources only, 1 wake-up sources.
// - mask and pending with source select raise interrupt; wake if mode 1.
// - a masked line never produces a wake-up event.
// - polarity bit 0 picks falling edge, 1 picks rising edge.
// - clearing one pending bit with another left gives a fresh rising edge.
// - edges set pending; software clears it or writes 1 to set it.
// - an edge during a write to its own half of the polarity register does not set pending.
// - NMI rising edge also ends stop mode, like a seventeenth line.
module wakeup_line_interrupt_unit #(
    parameter LINES = 16
)
(
    input wire CLK_I,
    input wire SYS_RST_I,
    input wire HSEL_I,
    input wire [31:0] HADDR_I,
    input wire [1:0] HTRANS_I,
    input wire HWRITE_I,
    input wire [2:0] HSIZE_I,
    input wire [31:0] HWDATA_I,
    input wire HREADY_I,
    output wire [31:0] HRDATA_O,
    output wire HREADYOUT_O,
    output wire HRESP_O,
    input wire [LINES-1:0] WAKE_LINES_I,
    input wire NMI_I,
    input wire EXT_STOP_N_I,
    input wire IN_STOP_I,
    output wire SHARED_IRQ_O,
    output wire WAKE_EVENT_O,
    output wire STOP_REQ_O
);
    localparam SEQ_IDLE = 2'd0;
    localparam SEQ_ONE = 2'd1;
    localparam SEQ_ZERO = 2'd2;

    wire [LINES+2:0] sync_w;
    wire [LINES-1:0] line_w;
    wire nmi_w;
    wire ext_stop_n_w;
    wire in_stop_w;

    reg [LINES-1:0] line_prev_reg;
    reg nmi_prev_reg;
    reg [7:0] ctrl_reg;
    reg [LINES-1:0] mask_reg;
    reg [LINES-1:0] pol_reg;
    reg [LINES-1:0] pend_reg;
    reg [LINES-1:0] pend_next;
    reg [1:0] seq_reg;
    reg stop_req_reg;
    reg exited_nmi_reg;
    reg irq_reg;
    reg gap_reg;
    reg wake_reg;
    reg [31:0] rdata_reg;

    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    reg [7:0] wd;
    wire [LINES-1:0] edge_w;
    wire take;
    wire wr_now;
    wire [LINES-1:0] active_w;
    wire any_active;
    wire nmi_rise;
    wire stop_ok;
    wire stop_bit_wr;

    line_sync #(
        .WIDTH(LINES + 3)
    )
    u_sync (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .async_i({IN_STOP_I, EXT_STOP_N_I, NMI_I, WAKE_LINES_I}),
        .sync_o(sync_w)
    );

    assign line_w = sync_w[LINES-1:0];
    assign nmi_w = sync_w[LINES];
    assign ext_stop_n_w = sync_w[LINES+1];
    assign in_stop_w = sync_w[LINES+2];

    // address phase capture, data phase write
    assign take = HSEL_I && HREADY_I && HTRANS_I[1];
    assign wr_now = wr_pend_reg;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign HRDATA_O = rdata_reg;

    always @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= take && HWRITE_I && (HADDR_I[31:10] == 22'h000000);
            wr_addr_reg <= HADDR_I[9:2];
        end
    end

    always @*
    begin
        wd = HWDATA_I[7:0];
    end

    assign active_w = mask_reg & pend_reg;
    assign any_active = |active_w;
    assign nmi_rise = nmi_w && !nmi_prev_reg;
    assign stop_ok = !nmi_w && ctrl_reg[`CTRL_WAKE_MODE_BIT] && !any_active &&
        (|mask_reg);
    assign stop_bit_wr = wr_now && (wr_addr_reg == `WAKE_CONTROL_IDX);

    // edge detection per line, polarity chosen per bit
    genvar g;
    generate
        for (g = 0; g < LINES; g = g + 1)
        begin : g_edge
            assign edge_w[g] = pol_reg[g] ?
                (line_w[g] && !line_prev_reg[g]) :
                (!line_w[g] && line_prev_reg[g]);
        end
    endgenerate

    always @*
    begin
        pend_next = pend_reg;
        if (wr_now && wr_addr_reg == `WAKE_PENDING_HIGH_IDX)
            pend_next[15:8] = wd;
        if (wr_now && wr_addr_reg == `WAKE_PENDING_LOW_IDX)
            pend_next[7:0] = wd;
        // hardware set wins over clear, except under a polarity write to the same half
        if (!(wr_now && wr_addr_reg == `WAKE_POLARITY_HIGH_IDX))
            pend_next[15:8] = pend_next[15:8] | edge_w[15:8];
        if (!(wr_now && wr_addr_reg == `WAKE_POLARITY_LOW_IDX))
            pend_next[7:0] = pend_next[7:0] | edge_w[7:0];
    end

    always @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            line_prev_reg <= {LINES{1'b0}};
            nmi_prev_reg <= 1'b0;
            ctrl_reg <= `REG_RESET;
            mask_reg <= {LINES{1'b0}};
            pol_reg <= {LINES{1'b0}};
            pend_reg <= {LINES{1'b0}};
        end
        else
        begin
            line_prev_reg <= line_w;
            nmi_prev_reg <= nmi_w;
            pend_reg <= pend_next;
            if (wr_now)
            begin
                case (wr_addr_reg)
                    `WAKE_CONTROL_IDX:
                        ctrl_reg[1:0] <= wd[1:0];
                    `WAKE_MASK_HIGH_IDX:
                        mask_reg[15:8] <= wd;
                    `WAKE_MASK_LOW_IDX:
                        mask_reg[7:0] <= wd;
                    `WAKE_POLARITY_HIGH_IDX:
                        pol_reg[15:8] <= wd;
                    `WAKE_POLARITY_LOW_IDX:
                        pol_reg[7:0] <= wd;
                    default:
                        ctrl_reg[1:0] <= ctrl_reg[1:0];
                endcase
            end
            // stop bit handling
            if (stop_bit_wr)
            begin
                case (seq_reg)
                    SEQ_IDLE:
                        ctrl_reg[`CTRL_STOP_BIT] <= wd[`CTRL_STOP_BIT];
                    SEQ_ONE:
                        ctrl_reg[`CTRL_STOP_BIT] <= wd[`CTRL_STOP_BIT];
                    SEQ_ZERO:
                        ctrl_reg[`CTRL_STOP_BIT] <= wd[`CTRL_STOP_BIT] &&
                            (stop_ok || nmi_w);
                    default:
                        ctrl_reg[`CTRL_STOP_BIT] <= 1'b0;
                endcase
            end
            else if (wr_now && seq_reg != SEQ_IDLE)
                ctrl_reg[`CTRL_STOP_BIT] <= 1'b0;
            else if (in_stop_w && any_active && !exited_nmi_reg)
                ctrl_reg[`CTRL_STOP_BIT] <= 1'b0;
        end
    end

    // stop sequence tracker
    always @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            seq_reg <= SEQ_IDLE;
            stop_req_reg <= 1'b0;
            exited_nmi_reg <= 1'b0;
        end
        else
        begin
            if (stop_bit_wr)
            begin
                case (seq_reg)
                    SEQ_IDLE:
                        seq_reg <= wd[`CTRL_STOP_BIT] ? SEQ_ONE : SEQ_IDLE;
                    SEQ_ONE:
                        seq_reg <= wd[`CTRL_STOP_BIT] ? SEQ_ONE : SEQ_ZERO;
                    SEQ_ZERO:
                    begin
                        seq_reg <= SEQ_IDLE;
                        stop_req_reg <= wd[`CTRL_STOP_BIT] && stop_ok;
                        exited_nmi_reg <= 1'b0;
                    end
                    default:
                        seq_reg <= SEQ_IDLE;
                endcase
            end
            else if (wr_now)
            begin
                seq_reg <= SEQ_IDLE;
                stop_req_reg <= 1'b0;
            end
            else if (stop_req_reg && (any_active || nmi_rise))
            begin
                stop_req_reg <= 1'b0;
                exited_nmi_reg <= nmi_rise && !any_active;
            end
        end
    end

    // shared interrupt with forced low gap after a pending clear
    always @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            irq_reg <= 1'b0;
            gap_reg <= 1'b0;
            wake_reg <= 1'b0;
        end
        else
        begin
            gap_reg <= wr_now && ((wr_addr_reg == `WAKE_PENDING_HIGH_IDX) ||
                (wr_addr_reg == `WAKE_PENDING_LOW_IDX)) &&
                ((pend_reg & ~pend_next) != {LINES{1'b0}});
            irq_reg <= ctrl_reg[`CTRL_SOURCE_SEL_BIT] && any_active && !gap_reg &&
                !(wr_now && ((wr_addr_reg == `WAKE_PENDING_HIGH_IDX) ||
                (wr_addr_reg == `WAKE_PENDING_LOW_IDX)) &&
                ((pend_reg & ~pend_next) != {LINES{1'b0}}));
            wake_reg <= ctrl_reg[`CTRL_WAKE_MODE_BIT] && any_active;
        end
    end

    assign SHARED_IRQ_O = irq_reg;
    assign WAKE_EVENT_O = wake_reg;
    assign STOP_REQ_O = stop_req_reg || !ext_stop_n_w;

    // read data in data phase
    always @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            rdata_reg <= 32'h00000000;
        else if (take && !HWRITE_I)
        begin
            case (HADDR_I[9:2])
                `WAKE_CONTROL_IDX:
                    rdata_reg <= {24'h000000, 5'h00, ctrl_reg[2:0]};
                `WAKE_MASK_HIGH_IDX:
                    rdata_reg <= {24'h000000, mask_reg[15:8]};
                `WAKE_MASK_LOW_IDX:
                    rdata_reg <= {24'h000000, mask_reg[7:0]};
                `WAKE_POLARITY_HIGH_IDX:
                    rdata_reg <= {24'h000000, pol_reg[15:8]};
                `WAKE_POLARITY_LOW_IDX:
                    rdata_reg <= {24'h000000, pol_reg[7:0]};
                `WAKE_PENDING_HIGH_IDX:
                    rdata_reg <= {24'h000000, pend_reg[15:8]};
                `WAKE_PENDING_LOW_IDX:
                    rdata_reg <= {24'h000000, pend_reg[7:0]};
                `WAKE_STATUS_IDX:
                    rdata_reg <= {29'h00000000, exited_nmi_reg, nmi_w,
                        stop_req_reg};
                default:
                    rdata_reg <= 32'h00000000;
            endcase
        end
    end
endmodule

/* File: wake_unit_sva.sv */
// checker of the wake-up unit port behaviour
`timescale 1ns/1ps
module wake_unit_sva #(
    parameter LINES = 16
)
(
    input wire CLK_I,
    input wire SYS_RST_I,
    input wire HSEL_I,
    input wire [31:0] HADDR_I,
    input wire [1:0] HTRANS_I,
    input wire HWRITE_I,
    input wire [2:0] HSIZE_I,
    input wire [31:0] HWDATA_I,
    input wire HREADY_I,
    input wire [31:0] HRDATA_O,
    input wire HREADYOUT_O,
    input wire HRESP_O,
    input wire [LINES-1:0] WAKE_LINES_I,
    input wire NMI_I,
    input wire EXT_STOP_N_I,
    input wire IN_STOP_I,
    input wire SHARED_IRQ_O,
    input wire WAKE_EVENT_O,
    input wire STOP_REQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    wire wr_taken = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
    wire rd_taken = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
    a_ready_always: assert property (HREADYOUT_O)
        else $error("ready dropped");
    a_resp_okay: assert property (!HRESP_O)
        else $error("response not okay");
    a_rdata_upper: assert property (HRDATA_O[31:8] == 24'h0)
        else $error("upper read bits set");
    a_rdata_holds: assert property (!rd_taken |=> $stable(HRDATA_O))
        else $error("read data changed without read");
    a_out_reset: assert property
        ($fell(SYS_RST_I) |-> !SHARED_IRQ_O && !WAKE_EVENT_O)
        else $error("outputs high after reset");
    a_ext_forces: assert property (!EXT_STOP_N_I [*4] |-> STOP_REQ_O)
        else $error("stop pin did not force stop");
    a_write_drops: assert property (EXT_STOP_N_I [*4] ##0 wr_taken
        |-> ##[1:3] !STOP_REQ_O)
        else $error("stop request survived a write");
    a_nmi_ends: assert property (!NMI_I ##1 (NMI_I && EXT_STOP_N_I) [*7]
        |-> !STOP_REQ_O)
        else $error("nmi did not end stop request");
    a_wake_blocks: assert property (EXT_STOP_N_I [*4] ##0 WAKE_EVENT_O
        |-> ##[0:2] !STOP_REQ_O)
        else $error("stop request with wake event");
    cover property (STOP_REQ_O && EXT_STOP_N_I);
    cover property (WAKE_EVENT_O);
    cover property ($fell(SHARED_IRQ_O));
endmodule

bind wakeup_line_interrupt_unit wake_unit_sva #(.LINES(LINES)) i_sva (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .WAKE_LINES_I(WAKE_LINES_I), .NMI_I(NMI_I),
    .EXT_STOP_N_I(EXT_STOP_N_I), .IN_STOP_I(IN_STOP_I),
    .SHARED_IRQ_O(SHARED_IRQ_O), .WAKE_EVENT_O(WAKE_EVENT_O),
    .STOP_REQ_O(STOP_REQ_O));

/* File: clock_unit_model.sv */
// behavioural clock and reset unit that enters stop on request
`timescale 1ns/1ps
module clock_unit_model
(
    input wire clk_i,
    input wire rst_i,
    input wire stop_req_i,
    output logic in_stop_o
);
    logic req_dly;
    // stop takes effect a couple of cycles after the request
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            req_dly <= 1'h0;
            in_stop_o <= 1'h0;
        end
        else
        begin
            req_dly <= stop_req_i;
            in_stop_o <= req_dly & stop_req_i;
        end
    end
endmodule

/* File: testbench.sv */
// self-checking bench of the wake-up line interrupt unit
`timescale 1ns/1ps
`include "wake_map.vh"
module testbench;
    logic clk;
    logic sys_rst = 1'h1;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] lines = 16'h0;
    logic nmi = 1'h0;
    logic ext_stop_n = 1'h1;
    logic [31:0] rd;
    wire [31:0] hrdata;
    wire hready, hresp, irq, wake, stop_req, in_stop;
    wire [2:0] outs = {stop_req, wake, irq};
    string nm[3] = '{"shared_irq", "wake_event", "stop_req"};
    int error_cnt = 0;
    int checked = 0;
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    wakeup_line_interrupt_unit i_wakeup_line_interrupt_unit (
        .CLK_I(clk), .SYS_RST_I(sys_rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .WAKE_LINES_I(lines),
        .NMI_I(nmi), .EXT_STOP_N_I(ext_stop_n), .IN_STOP_I(in_stop),
        .SHARED_IRQ_O(irq), .WAKE_EVENT_O(wake), .STOP_REQ_O(stop_req));
    clock_unit_model i_clock_unit_model (.clk_i(clk), .rst_i(sys_rst),
        .stop_req_i(stop_req), .in_stop_o(in_stop));
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx,
        input logic [7:0] wd);
        hsel <= 1'h1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hready !== 1'h1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'h1, idx, wd);
    endtask
    task automatic rdchk(input string name, input logic [7:0] idx,
        input logic [31:0] exp);
        bus(1'h0, idx, 8'h0);
        check(name, rd, exp);
    endtask
    // early set: stop at first match, else wait out the whole span and check the last sample
    task automatic lvl(input int s, input logic v, input int n,
        input bit early);
        for (int k = 0; k < n; k++)
        begin
            @(posedge clk);
            #1;
            if (early && outs[s] === v)
                break;
        end
        check(nm[s], {31'h0, outs[s]}, {31'h0, v});
        @(posedge clk);
    endtask
    task automatic seq(input logic [7:0] base);
        wr(`WAKE_CONTROL_IDX, base | 8'h04);
        wr(`WAKE_CONTROL_IDX, base);
        wr(`WAKE_CONTROL_IDX, base | 8'h04);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        for (int i = 0; i < 9; i++)
            rdchk("reset value", 8'(i == 8 ? 'hf0 : 'hf8 + i), 32'h0);
        wr(`WAKE_MASK_HIGH_IDX, 8'ha5);
        rdchk("mask high", `WAKE_MASK_HIGH_IDX, 32'ha5);
        wr(8'hf0, 8'hff);
        rdchk("unmapped", 8'hf0, 32'h0);
        $display("test registers done");
        wr(`WAKE_POLARITY_LOW_IDX, 8'h01);
        wr(`WAKE_MASK_LOW_IDX, 8'h03);
        wr(`WAKE_CONTROL_IDX, 8'h02);
        lines <= 16'h0003;
        repeat (8) @(posedge clk);
        rdchk("pending low", `WAKE_PENDING_LOW_IDX, 32'h01);
        lvl(0, 1'h1, 4, 1'h1);
        lvl(1, 1'h0, 4, 1'h0);
        lines <= 16'h0001;
        repeat (8) @(posedge clk);
        rdchk("pending low", `WAKE_PENDING_LOW_IDX, 32'h03);
        wr(`WAKE_PENDING_LOW_IDX, 8'h02);
        lvl(0, 1'h0, 4, 1'h1);
        lvl(0, 1'h1, 6, 1'h1);
        wr(`WAKE_PENDING_LOW_IDX, 8'h00);
        wr(`WAKE_CONTROL_IDX, 8'h03);
        wr(`WAKE_PENDING_HIGH_IDX, 8'h02);
        rdchk("pending high", `WAKE_PENDING_HIGH_IDX, 32'h02);
        lvl(1, 1'h0, 6, 1'h0);
        wr(`WAKE_PENDING_HIGH_IDX, 8'h00);
        $display("test lines done");
        lines <= 16'h0000;
        wr(`WAKE_CONTROL_IDX, 8'h07);
        rdchk("control", `WAKE_CONTROL_IDX, 32'h07);
        wr(`WAKE_MASK_LOW_IDX, 8'h03);
        rdchk("control", `WAKE_CONTROL_IDX, 32'h03);
        wr(`WAKE_CONTROL_IDX, 8'h03);
        wr(`WAKE_CONTROL_IDX, 8'h07);
        lvl(2, 1'h0, 6, 1'h0);
        // abort the open 1 so the next sequence starts clean
        wr(`WAKE_MASK_LOW_IDX, 8'h03);
        wr(`WAKE_CONTROL_IDX, 8'h03);
        nmi <= 1'h1;
        seq(8'h03);
        lvl(2, 1'h0, 6, 1'h0);
        rdchk("control", `WAKE_CONTROL_IDX, 32'h07);
        nmi <= 1'h0;
        wr(`WAKE_CONTROL_IDX, 8'h02);
        seq(8'h02);
        lvl(2, 1'h0, 6, 1'h0);
        wr(`WAKE_CONTROL_IDX, 8'h03);
        seq(8'h03);
        lvl(2, 1'h1, 4, 1'h1);
        repeat (6) @(posedge clk);
        lines <= 16'h0001;
        lvl(2, 1'h0, 10, 1'h1);
        lvl(1, 1'h1, 4, 1'h1);
        rdchk("control", `WAKE_CONTROL_IDX, 32'h03);
        wr(`WAKE_PENDING_LOW_IDX, 8'h00);
        wr(`WAKE_CONTROL_IDX, 8'h03);
        seq(8'h03);
        lvl(2, 1'h1, 4, 1'h1);
        repeat (6) @(posedge clk);
        nmi <= 1'h1;
        lvl(2, 1'h0, 10, 1'h1);
        rdchk("control", `WAKE_CONTROL_IDX, 32'h07);
        rdchk("status", `WAKE_STATUS_IDX, 32'h06);
        nmi <= 1'h0;
        wr(`WAKE_CONTROL_IDX, 8'h03);
        ext_stop_n <= 1'h0;
        lvl(2, 1'h1, 6, 1'h1);
        ext_stop_n <= 1'h1;
        lvl(2, 1'h0, 6, 1'h1);
        wr(`WAKE_POLARITY_LOW_IDX, 8'h03);
        lines <= 16'h0003;
        // edge reaches the detector as the polarity write lands
        @(posedge clk);
        wr(`WAKE_POLARITY_LOW_IDX, 8'h03);
        rdchk("pending low", `WAKE_PENDING_LOW_IDX, 32'h00);
        $display("test stop done");
        results;
    end
endmodule
